/* File: verilog/ctm_pkg.sv */
package ctm_pkg;

    // =========================================================
    // timing
    localparam int unsigned CLK_HZ     = 100_000_000;
    localparam int unsigned TICK_MS    = 1;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DIV_W      = 17;
    localparam logic [8:0]  WAIT_MIN_MS = 9'h01E;
    localparam logic [8:0]  WAIT_MAX_MS = 9'h12C;
    localparam logic [8:0]  WAIT_RST_MS = 9'h01E;
    localparam logic [8:0]  MEAS_MS     = 9'h064;

    // =========================================================
    // setting limits and defaults
    localparam logic [2:0] SEL_MAX     = 3'h4;
    localparam logic [2:0] SEL_RST     = 3'h0;
    localparam logic       TYPE_BURN   = 1'b0;
    localparam logic       TYPE_PLAIN  = 1'b1;
    localparam logic [5:0] TURNS_MAX   = 6'h28;
    localparam logic [5:0] TURNS_RST   = 6'h08;
    localparam logic [5:0] TURNS_ZERO  = 6'h08;
    localparam logic [2:0] LOOPS_MAX   = 3'h6;
    localparam logic [2:0] LOOPS_RST   = 3'h1;
    localparam logic [2:0] LOOPS_ZERO  = 3'h1;

    // =========================================================
    // range arithmetic, currents in 0.1 A units
    localparam logic [15:0] DISP_NUM = 16'h0578;
    localparam logic [15:0] MEAS_NUM = 16'h03E8;
    localparam logic [15:0] HI_DIV   = 16'h0010;
    localparam logic [15:0] LO_DIV   = 16'h0002;

    // =========================================================
    // register map (byte addresses) and fields
    localparam logic [7:0] ADDR_CFG0  = 8'h00;
    localparam logic [7:0] ADDR_CFG1  = 8'h04;
    localparam logic [7:0] ADDR_WAIT0 = 8'h08;
    localparam logic [7:0] ADDR_WAIT1 = 8'h0C;
    localparam logic [7:0] ADDR_CUR0  = 8'h10;
    localparam logic [7:0] ADDR_CUR1  = 8'h14;
    localparam logic [7:0] ADDR_RNG0  = 8'h18;
    localparam logic [7:0] ADDR_RNG1  = 8'h1C;
    localparam logic [7:0] ADDR_LOW   = 8'h20;
    localparam logic [7:0] ADDR_STAT  = 8'h24;
    localparam logic [7:0] ADDR_MASK  = 8'h28;
    localparam int unsigned F_SEL   = 0;
    localparam int unsigned F_TYPE  = 3;
    localparam int unsigned F_TURNS = 8;
    localparam int unsigned F_LOOPS = 16;
    localparam int unsigned ST_DONE  = 0;
    localparam int unsigned ST_ALARM = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef logic [15:0] ctm_amp_t;

    typedef struct packed {
        logic [2:0] sel;
        logic       kind;
        logic [5:0] turns;
        logic [2:0] loops;
        logic [8:0] wait_ms;
    } ctm_cfg_s;

    typedef struct packed {
        ctm_amp_t disp_hi;
        ctm_amp_t meas_lo;
        ctm_amp_t meas_hi;
    } ctm_range_s;

    typedef enum logic [1:0] {
        CTM_IDLE = 2'b00,
        CTM_WAIT = 2'b01,
        CTM_MEAS = 2'b11
    } ctm_state_e;

    localparam ctm_cfg_s CFG_RST = '{SEL_RST, TYPE_BURN, TURNS_RST, LOOPS_RST, WAIT_RST_MS};

    function automatic logic [31:0] ctm_wmerge(input logic [31:0] old,
                                               input logic [31:0] dat,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = dat[i*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

/* File: verilog/ctm_range.sv */
module ctm_range
    import ctm_pkg::*;
(
    input  wire logic [5:0] turns_in,
    input  wire logic [2:0] loops_in,
    output ctm_range_s      range_out
);

    // =========================================================
    // zero codes stand for the common transformer
    function automatic logic [15:0] eff_turns(input logic [5:0] t);
        return {10'h000, (t == 6'h00) ? TURNS_ZERO : t};
    endfunction

    function automatic logic [15:0] eff_loops(input logic [2:0] l);
        return {13'h0000, (l == 3'h0) ? LOOPS_ZERO : l};
    endfunction

    logic [15:0] t_w;
    logic [15:0] l_w;

    always_comb begin
        t_w = eff_turns(turns_in);
        l_w = eff_loops(loops_in);
        // integer 0.1 A arithmetic truncates, so error stays under 0.1 A
        range_out.disp_hi = (t_w * DISP_NUM) / (HI_DIV * l_w);
        range_out.meas_hi = (t_w * MEAS_NUM) / (HI_DIV * l_w);
        range_out.meas_lo = (t_w + l_w) / (LO_DIV * l_w);
    end

endmodule // ctm_range

/* File: verilog/ctm_seq.sv */
module ctm_seq
    import ctm_pkg::*;
(
    input  wire logic     mclk_in,
    input  wire logic     rst_in,
    input  wire logic     tick_in,
    input  ctm_cfg_s      cfg_in,
    input  wire logic [4:0] outs_in,
    input  ctm_amp_t      sample_in,
    output ctm_amp_t      on_cur_out,
    output ctm_amp_t      off_cur_out,
    output logic          done_out
);

    ctm_state_e  st_r,   st_nxt;
    logic [8:0]  cnt_r,  cnt_nxt;
    logic        prev_r, prev_nxt;
    ctm_amp_t    on_r,   on_nxt;
    ctm_amp_t    off_r,  off_nxt;
    logic        done_r, done_nxt;
    logic        mon;
    logic        toggle;

    // =========================================================
    // monitored output and sequence
    always_comb begin
        mon      = (cfg_in.sel > SEL_MAX) ? 1'b0 : outs_in[cfg_in.sel];
        toggle   = mon != prev_r;
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        on_nxt   = on_r;
        off_nxt  = off_r;
        done_nxt = 1'b0;
        prev_nxt = mon;
        if (cfg_in.kind == TYPE_PLAIN) begin
            st_nxt  = CTM_IDLE;
            on_nxt  = sample_in;
            off_nxt = 16'h0000;
        end else if (toggle) begin
            st_nxt  = CTM_WAIT;
            cnt_nxt = 9'h000;
        end else begin
            case (st_r)
                CTM_IDLE: begin
                end
                CTM_WAIT: begin
                    // the first tick is partial, so one extra tick makes the wait a minimum
                    if (tick_in) begin
                        if (cnt_r == cfg_in.wait_ms) begin
                            st_nxt  = CTM_MEAS;
                            cnt_nxt = 9'h000;
                        end else begin
                            cnt_nxt = 9'(cnt_r + 9'h001);
                        end
                    end
                end
                CTM_MEAS: begin
                    if (tick_in) begin
                        if (cnt_r == MEAS_MS) begin
                            st_nxt   = CTM_IDLE;
                            done_nxt = 1'b1;
                            if (mon) begin
                                on_nxt = sample_in;
                            end else begin
                                off_nxt = sample_in;
                            end
                        end else begin
                            cnt_nxt = 9'(cnt_r + 9'h001);
                        end
                    end
                end
                default: begin
                    st_nxt = CTM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r   <= CTM_IDLE;
            cnt_r  <= 9'h000;
            prev_r <= 1'b0;
            on_r   <= 16'h0000;
            off_r  <= 16'h0000;
            done_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            prev_r <= prev_nxt;
            on_r   <= on_nxt;
            off_r  <= off_nxt;
            done_r <= done_nxt;
        end
    end

    assign on_cur_out  = on_r;
    assign off_cur_out = off_r;
    assign done_out    = done_r;

    // =========================================================
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    plain_off_zero_a: assert property (cfg_in.kind == TYPE_PLAIN |=> off_r == 16'h0000)
        else $error("off current not zero in plain type");
    wait_before_meas_a: assert property (
        (st_r == CTM_WAIT && st_nxt == CTM_MEAS) |-> (cnt_r == cfg_in.wait_ms && tick_in))
        else $error("measurement began before wait elapsed");
    done_after_meas_a: assert property (
        done_r |-> ($past(st_r) == CTM_MEAS && $past(cnt_r) == MEAS_MS))
        else $error("measurement completed at wrong count");
    toggle_restart_a: assert property (
        (cfg_in.kind == TYPE_BURN && toggle) |=> (st_r == CTM_WAIT && cnt_r == 9'h000))
        else $error("toggle did not restart the sequence");
    store_side_a: assert property (
        (done_r && $past(cfg_in.kind) == TYPE_BURN)
            |-> (prev_r ? on_r == $past(sample_in) : off_r == $past(sample_in)))
        else $error("measurement stored on wrong side");
    restart_cov: cover property (st_r == CTM_MEAS && toggle && cfg_in.kind == TYPE_BURN);
    done_cov: cover property (done_r);

endmodule // ctm_seq

/* File: verilog/ctm_top.sv */
module ctm_top
    import ctm_pkg::*;
#(
    parameter int unsigned CLK_PER_MS = CYC_PER_MS
) (
    input  wire logic            mclk_in,
    input  wire logic            rst_in,
    input  wire logic [7:0]      s_axi_awaddr_in,
    input  wire logic            s_axi_awvalid_in,
    output logic                 s_axi_awready_out,
    input  wire logic [31:0]     s_axi_wdata_in,
    input  wire logic [3:0]      s_axi_wstrb_in,
    input  wire logic            s_axi_wvalid_in,
    output logic                 s_axi_wready_out,
    output logic [1:0]           s_axi_bresp_out,
    output logic                 s_axi_bvalid_out,
    input  wire logic            s_axi_bready_in,
    input  wire logic [7:0]      s_axi_araddr_in,
    input  wire logic            s_axi_arvalid_in,
    output logic                 s_axi_arready_out,
    output logic [31:0]          s_axi_rdata_out,
    output logic [1:0]           s_axi_rresp_out,
    output logic                 s_axi_rvalid_out,
    input  wire logic            s_axi_rready_in,
    input  wire logic            two_ct_fitted_in,
    input  wire logic [4:0]      heater_outs_in,
    input  wire logic [1:0][15:0] ct_sample_in,
    output logic                 ct_input_failure_alarm_out,
    output logic                 irq_out
);

    ctm_cfg_s        cfg_r [2];
    ctm_cfg_s        cfg_nxt [2];
    ctm_range_s      rng [2];
    ctm_amp_t        on_cur [2];
    ctm_amp_t        off_cur [2];
    logic [1:0]      done;
    logic [1:0]      over_r,  over_nxt;
    logic [3:0]      stat_r,  stat_nxt;
    logic [3:0]      mask_r,  mask_nxt;
    logic [3:0]      stat_set;
    logic [3:0]      stat_clr;
    logic [DIV_W-1:0] div_r,  div_nxt;
    logic            tick_r,  tick_nxt;
    logic            bvalid_r, bvalid_nxt;
    logic [1:0]      bresp_r, bresp_nxt;
    logic            rvalid_r, rvalid_nxt;
    logic [1:0]      rresp_r, rresp_nxt;
    logic [31:0]     rdata_r, rdata_nxt;
    logic            wr_go;
    logic            rd_go;
    logic [31:0]     wval;

    // =========================================================
    // millisecond tick
    always_comb begin
        tick_nxt = 1'b0;
        div_nxt  = DIV_W'(div_r + 1'b1);
        if (div_r == DIV_W'(CLK_PER_MS - 1)) begin
            div_nxt  = '0;
            tick_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            div_r  <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // =========================================================
    // channels
    generate
        for (genvar c = 0; c < 2; c++) begin : g_ch
            ctm_range u_range (
                .turns_in  (cfg_r[c].turns),
                .loops_in  (cfg_r[c].loops),
                .range_out (rng[c])
            );
            ctm_seq u_seq (
                .mclk_in     (mclk_in),
                .rst_in      (rst_in),
                .tick_in     (tick_r),
                .cfg_in      (cfg_r[c]),
                .outs_in     (heater_outs_in),
                .sample_in   (ct_sample_in[c]),
                .on_cur_out  (on_cur[c]),
                .off_cur_out (off_cur[c]),
                .done_out    (done[c])
            );
        end
    endgenerate

    // =========================================================
    // bus slave: one write and one read outstanding at most
    always_comb begin
        wr_go = s_axi_awvalid_in && s_axi_wvalid_in && !bvalid_r;
        rd_go = s_axi_arvalid_in && !rvalid_r;
        wval  = s_axi_wdata_in;
        for (int c = 0; c < 2; c++) begin
            cfg_nxt[c] = cfg_r[c];
        end
        mask_nxt   = mask_r;
        stat_clr   = 4'h0;
        bresp_nxt  = bresp_r;
        bvalid_nxt = bvalid_r && !s_axi_bready_in;
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = RESP_OKAY;
            case (s_axi_awaddr_in)
                ADDR_CFG0, ADDR_CFG1: begin
                    // bad codes keep the old field; option gate on channel two
                    if (s_axi_awaddr_in == ADDR_CFG0 || two_ct_fitted_in) begin
                        wval = ctm_wmerge({8'h00, 5'h00, cfg_r[s_axi_awaddr_in[2]].loops,
                                          2'h0, cfg_r[s_axi_awaddr_in[2]].turns,
                                          4'h0, cfg_r[s_axi_awaddr_in[2]].kind,
                                          cfg_r[s_axi_awaddr_in[2]].sel},
                                          s_axi_wdata_in, s_axi_wstrb_in);
                        if (wval[F_SEL +: 3] <= SEL_MAX) begin
                            cfg_nxt[s_axi_awaddr_in[2]].sel = wval[F_SEL +: 3];
                        end
                        cfg_nxt[s_axi_awaddr_in[2]].kind = wval[F_TYPE];
                        if (wval[F_TURNS +: 6] <= TURNS_MAX) begin
                            cfg_nxt[s_axi_awaddr_in[2]].turns = wval[F_TURNS +: 6];
                        end
                        if (wval[F_LOOPS +: 3] <= LOOPS_MAX) begin
                            cfg_nxt[s_axi_awaddr_in[2]].loops = wval[F_LOOPS +: 3];
                        end
                    end
                end
                ADDR_WAIT0, ADDR_WAIT1: begin
                    if (s_axi_awaddr_in == ADDR_WAIT0 || two_ct_fitted_in) begin
                        wval = ctm_wmerge({23'h000000, cfg_r[s_axi_awaddr_in[2]].wait_ms},
                                          s_axi_wdata_in, s_axi_wstrb_in);
                        // out of range values clamp to the nearest limit
                        if (wval > {23'h000000, WAIT_MAX_MS}) begin
                            cfg_nxt[s_axi_awaddr_in[2]].wait_ms = WAIT_MAX_MS;
                        end else if (wval < {23'h000000, WAIT_MIN_MS}) begin
                            cfg_nxt[s_axi_awaddr_in[2]].wait_ms = WAIT_MIN_MS;
                        end else begin
                            cfg_nxt[s_axi_awaddr_in[2]].wait_ms = wval[8:0];
                        end
                    end
                end
                ADDR_STAT: begin
                    if (s_axi_wstrb_in[0]) begin
                        stat_clr = s_axi_wdata_in[3:0];
                    end
                end
                ADDR_MASK: begin
                    if (s_axi_wstrb_in[0]) begin
                        mask_nxt = s_axi_wdata_in[3:0];
                    end
                end
                ADDR_CUR0, ADDR_CUR1, ADDR_RNG0, ADDR_RNG1, ADDR_LOW: begin
                end
                default: begin
                    bresp_nxt = RESP_SLVERR;
                end
            endcase
        end
        rvalid_nxt = rvalid_r && !s_axi_rready_in;
        rdata_nxt  = rdata_r;
        rresp_nxt  = rresp_r;
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            case (s_axi_araddr_in)
                ADDR_CFG0, ADDR_CFG1: begin
                    rdata_nxt = {13'h0000, cfg_r[s_axi_araddr_in[2]].loops, 2'h0,
                                 cfg_r[s_axi_araddr_in[2]].turns, 4'h0,
                                 cfg_r[s_axi_araddr_in[2]].kind,
                                 cfg_r[s_axi_araddr_in[2]].sel};
                end
                ADDR_WAIT0, ADDR_WAIT1: begin
                    rdata_nxt = {23'h000000, cfg_r[s_axi_araddr_in[2]].wait_ms};
                end
                ADDR_CUR0, ADDR_CUR1: begin
                    rdata_nxt = {off_cur[s_axi_araddr_in[2]], on_cur[s_axi_araddr_in[2]]};
                end
                ADDR_RNG0, ADDR_RNG1: begin
                    rdata_nxt = {rng[s_axi_araddr_in[2]].meas_hi,
                                 rng[s_axi_araddr_in[2]].disp_hi};
                end
                ADDR_LOW: begin
                    rdata_nxt = {rng[1].meas_lo, rng[0].meas_lo};
                end
                ADDR_STAT: begin
                    rdata_nxt = {28'h0000000, stat_r};
                end
                ADDR_MASK: begin
                    rdata_nxt = {28'h0000000, mask_r};
                end
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    // =========================================================
    // alarm and sticky status; a set in the clearing cycle wins
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            // a saturated front end can hide a very large overcurrent
            over_nxt[c] = ct_sample_in[c] > rng[c].disp_hi;
        end
        stat_set = {over_nxt & ~over_r, done};
        stat_nxt = (stat_r & ~stat_clr) | stat_set;
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_r[0] <= CFG_RST;
            cfg_r[1] <= CFG_RST;
            mask_r   <= 4'h0;
            stat_r   <= 4'h0;
            over_r   <= 2'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r  <= RESP_OKAY;
            rdata_r  <= 32'h00000000;
        end else begin
            cfg_r[0] <= cfg_nxt[0];
            cfg_r[1] <= cfg_nxt[1];
            mask_r   <= mask_nxt;
            stat_r   <= stat_nxt;
            over_r   <= over_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r  <= rresp_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign s_axi_awready_out          = wr_go;
    assign s_axi_wready_out           = wr_go;
    assign s_axi_bvalid_out           = bvalid_r;
    assign s_axi_bresp_out            = bresp_r;
    assign s_axi_arready_out          = rd_go;
    assign s_axi_rvalid_out           = rvalid_r;
    assign s_axi_rresp_out            = rresp_r;
    assign s_axi_rdata_out            = rdata_r;
    assign ct_input_failure_alarm_out = |over_r;
    assign irq_out                    = |(stat_r & mask_r);

    // =========================================================
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    tick_period_a: assert property (tick_r |-> $past(div_r) == DIV_W'(CLK_PER_MS - 1))
        else $error("millisecond tick out of period");
    wait_limits_a: assert property (
        cfg_r[0].wait_ms >= WAIT_MIN_MS && cfg_r[0].wait_ms <= WAIT_MAX_MS &&
        cfg_r[1].wait_ms >= WAIT_MIN_MS && cfg_r[1].wait_ms <= WAIT_MAX_MS)
        else $error("wait time outside limits");
    turns_limit_a: assert property (
        cfg_r[0].turns <= TURNS_MAX && cfg_r[0].loops <= LOOPS_MAX &&
        cfg_r[1].turns <= TURNS_MAX && cfg_r[1].loops <= LOOPS_MAX)
        else $error("turns or loops outside limits");
    alarm_set_a: assert property (
        (ct_sample_in[0] > rng[0].disp_hi) |=> (over_r[0] && ct_input_failure_alarm_out))
        else $error("alarm not raised above display range");
    option_gate_a: assert property (
        !two_ct_fitted_in |=> cfg_r[1] == $past(cfg_r[1]))
        else $error("channel two changed without option");
    done_sticky_a: assert property (
        done[0] |=> stat_r[ST_DONE])
        else $error("completion not recorded");
    alarm_cov: cover property (ct_input_failure_alarm_out);
    wr_rd_cov: cover property (wr_go ##1 rd_go);
    irq_cov: cover property (irq_out && stat_r[ST_ALARM + 1]);

endmodule // ctm_top

/* File: test/ctm_ct_model.sv */
module ctm_ct_model (
    input  wire logic        heater_in,
    input  wire logic [15:0] on_amp_in,
    input  wire logic [15:0] off_amp_in,
    output logic      [15:0] sample_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // load current while the heater conducts, leakage while it is off
    assign sample_out = heater_in ? on_amp_in : off_amp_in;
endmodule // ctm_ct_model

/* File: test/tb.sv */
module tb import ctm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, fit = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [4:0] outs = 0;
    logic [15:0] a_on = 0, a_off = 0, a_two = 0;
    wire [1:0][15:0] smp;
    logic [1:0] resp, br, rr;
    logic awr, wrd, bv, arr, rv, alarm, irq;
    logic [31:0] rdo;
    int failures = 0, tests_run = 0, t, l, te, le, ks = 0;
    int seed = 32'hDCD28B8A;
    time t0;
    always #5 mclk = ~mclk;
    assign smp[1] = a_two;
    ctm_ct_model i_ct (.heater_in(outs[ks]), .on_amp_in(a_on), .off_amp_in(a_off),
        .sample_out(smp[0]));
    ctm_top #(.CLK_PER_MS(10)) i_dut (.mclk_in(mclk), .rst_in(rst),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrd), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(bre), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rdo), .s_axi_rresp_out(rr),
        .s_axi_rvalid_out(rv), .s_axi_rready_in(rre), .two_ct_fitted_in(fit),
        .heater_outs_in(outs), .ct_sample_in(smp), .ct_input_failure_alarm_out(alarm),
        .irq_out(irq));
    // ==========================================================
    // bus and check tasks
    task automatic chk(logic [33:0] g, logic [33:0] e);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask
    // ready and answers are looked at on the falling edge, where they are settled
    task automatic axw(logic [7:0] a, logic [31:0] d);
        @(posedge mclk); awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
        do @(negedge mclk); while (!(awr && wrd));
        @(posedge mclk); awv <= 0; wv <= 0;
        do @(negedge mclk); while (!bv);
        resp = br;
        @(posedge mclk); bre <= 0;
        @(negedge mclk);
    endtask
    task automatic axr(logic [7:0] a);
        @(posedge mclk); ara <= a; arv <= 1; rre <= 1;
        do @(negedge mclk); while (!arr);
        @(posedge mclk); arv <= 0;
        do @(negedge mclk); while (!rv);
        resp = rr;
        rdat = rdo;
        @(posedge mclk); rre <= 0;
    endtask
    task automatic meas(logic [31:0] e);
        while (!irq && $time - t0 < 20000) @(negedge mclk);
        chk(($time - t0) > 13000 && ($time - t0) < 13450, 1);
        axr(ADDR_CUR0); chk(rdat, e);
        axr(ADDR_STAT); chk(rdat[0], 1);
        axw(ADDR_MASK, 0); chk(irq, 0);
        axw(ADDR_MASK, 1); chk(irq, 1);
        axw(ADDR_STAT, 1); chk(irq, 0);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #400000;
        failures++;
        end_of_test();
    end
    // ==========================================================
    // scenarios
    initial begin
        repeat (3) @(posedge mclk);
        rst <= 0;
        axr(ADDR_CFG0); chk({resp, rdat}, 34'h0_0001_0800);
        axr(ADDR_WAIT0); chk({resp, rdat}, 34'h1E);
        axr(8'h40); chk(resp, RESP_SLVERR);
        axw(8'h40, 0); chk(resp, RESP_SLVERR);
        axw(ADDR_CFG1, 32'h402); axr(ADDR_CFG1); chk(rdat, 32'h10800);
        fit <= 1;
        for (int i = 0; i < 8; i++) begin
            t = i ? {$random(seed)} % 41 : 0;
            l = i ? {$random(seed)} % 7 : 0;
            te = t ? t : 8;
            le = l ? l : 1;
            axw(ADDR_CFG1, (l << 16) | (t << 8));
            axr(ADDR_RNG1); chk(rdat, (te * 1000 / (16 * le)) << 16 | te * 1400 / (16 * le));
            axr(ADDR_LOW); chk(rdat[31:16], (te + le) / (2 * le));
        end
        axw(ADDR_WAIT0, 32'h1FF); axr(ADDR_WAIT0); chk(rdat, 32'h12C);
        axw(ADDR_WAIT0, 5); axr(ADDR_WAIT0); chk(rdat, 32'h1E);
        axw(ADDR_MASK, 1);
        for (int k = 0; k < 5; k++) begin
            axw(ADDR_CFG0, k);
            @(posedge mclk); outs[k] <= 1; t0 = $time;
            ks <= k;
            a_on <= 16'({$random(seed)} % 600);
            a_off <= 16'({$random(seed)} % 600);
            // the other outputs toggling must not restart the wait
            repeat (100) @(posedge mclk); outs <= outs ^ (5'h1F ^ (5'h1 << k));
            repeat (100) @(posedge mclk); outs <= outs ^ (5'h1F ^ (5'h1 << k));
            meas({k > 0 ? te[15:0] : 16'h0, a_on});
            te = a_off;
            @(posedge mclk); outs[k] <= 0;
            repeat (100) @(posedge mclk); outs[k] <= 1;
            repeat (100) @(posedge mclk); outs[k] <= 0; t0 = $time;
            meas({a_off, a_on});
        end
        axw(ADDR_CFG0, 32'h8);
        axw(ADDR_CFG1, 32'h8);
        @(posedge mclk); ks <= 0; a_on <= 500; a_off <= 500; a_two <= 16'h0123;
        repeat (4) @(negedge mclk);
        axr(ADDR_CUR0); chk(rdat, 32'h1F4);
        axr(ADDR_CUR1); chk(rdat, 32'h123);
        @(posedge mclk); a_on <= 700; a_off <= 700;
        repeat (4) @(negedge mclk); chk(alarm, 0);
        @(posedge mclk); a_on <= 701; a_off <= 701;
        repeat (4) @(negedge mclk); chk(alarm, 1);
        end_of_test();
    end
endmodule // tb
